// File: testbench.sv
// Self-checking bench for the burst port: registers, bursts both ways, resets.
// Assumes the port, its bound monitor and the host model are compiled first.
`timescale 1ns/1ps
`include "udb_defines.vh"
`define UDB_CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin \
   fail_count++; $display("[FAIL] %0t %s", $time, m); end end
module testbench;
   logic        ref_clk = 1'b0, hclk = 1'b0, reset_n = 1'b0;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h0;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   wire  [31:0] wb_dat_o;
   wire         wb_ack_o, dmack_i, stop_i, hrdy_strobe_i, dmarq_o, drdy_strobe_o;
   wire         ready_o, data_oe;
   wire  [15:0] data_i, data_o;
   int          fail_count = 0, cmp_count = 0, cyc_n = 0;
   logic [63:0] exp_q[$], e;
   logic [15:0] w, got;
   // ====================
   // Clocks, parts and bus tasks
   always #4 ref_clk = ~ref_clk;
   initial begin
      #3;
      forever #40 hclk = ~hclk;
   end
   udb_port DUT (.ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dmack_i(dmack_i),
      .stop_i(stop_i), .hrdy_strobe_i(hrdy_strobe_i), .dmarq_o(dmarq_o), .ready_o(ready_o),
      .drdy_strobe_o(drdy_strobe_o), .data_i(data_i), .data_o(data_o), .data_oe(data_oe));
   udb_host_model host (.hclk(hclk), .dmarq_o(dmarq_o), .drdy_strobe_o(drdy_strobe_o),
      .data_o(data_o), .data_oe(data_oe), .dmack_i(dmack_i), .stop_i(stop_i),
      .hrdy_strobe_i(hrdy_strobe_i), .data_i(data_i));
   task automatic wb(input [7:0] a, input we, input [31:0] d, input [3:0] s);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic wr(input [7:0] a, input [31:0] d);
      wb(a, 1'b1, d, 4'hF);
   endtask
   task automatic rd(input [7:0] a, input [31:0] d, input [31:0] m);
      exp_q.push_back({m, d & m});
      wb(a, 1'b0, 32'h0, 4'hF);
   endtask
   task automatic cmd(input [1:0] c);
      wr(`UDB_ADR_CMD, {30'h0, c});
   endtask
   task test_done();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         fail_count++;
         $display("[FAIL] %0t timeout", $time);
         test_done();
      end
      if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i) begin
         e = exp_q.pop_front();
         `UDB_CHK(wb_dat_o & e[63:32], e[31:0], "register read")
      end
   end
   // ====================
   // Scenarios
   initial begin
      void'($urandom(32'h9413));
      w = 16'($urandom());
      repeat (8) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      `UDB_CHK(ready_o, 1'b1, "ready after reset")
      rd(`UDB_ADR_CTRL, 32'h0, 32'h7F);
      rd(8'hFC, 32'h0, 32'hFFFFFFFF);
      for (int m = 0; m < 8; m++) begin
         wr(`UDB_ADR_CTRL, 32'h8 | m);
         rd(`UDB_ADR_CTRL, 32'h8 | (m > 4 ? 4 : m), 32'hF);
      end
      wb(`UDB_ADR_CTRL, 1'b1, 32'h2, 4'h0);
      rd(`UDB_ADR_CTRL, 32'hC, 32'hF);
      wr(`UDB_ADR_CTRL, 32'h2);
      wr(`UDB_ADR_TXDATA, {16'h0, w});
      cmd(`UDB_CMD_READ);
      @(posedge ref_clk);
      `UDB_CHK(dmarq_o, 1'b0, "request while disabled")
      wr(`UDB_ADR_CTRL, 32'h2A);
      cmd(`UDB_CMD_READ);
      @(posedge ref_clk);
      `UDB_CHK(ready_o, 1'b0, "ready during command")
      rd(`UDB_ADR_STATUS, 32'h80, 32'h88);
      // No register traffic while a burst runs.
      host.rx_word(got, 1'b0);
      @(posedge ref_clk);
      `UDB_CHK(got, w, "read burst word")
      rd(`UDB_ADR_ERROR, 32'h0, 32'h80);
      cmd(`UDB_CMD_DONE);
      @(posedge ref_clk);
      `UDB_CHK(ready_o, 1'b1, "ready after completion")
      cmd(`UDB_CMD_WRITE);
      for (int k = 0; k < 2; k++) begin
         w = 16'($urandom());
         host.tx_word(w, k == 0);
         @(posedge ref_clk);
         rd(`UDB_ADR_RXDATA, {15'h0, 1'b1, w}, 32'h1FFFF);
         rd(`UDB_ADR_ERROR, 32'h80, 32'h80);
         rd(`UDB_ADR_HOSTCRC, {16'h0, host.crc16(w) ^ {15'h0, k == 0}}, 32'hFFFF);
         rd(`UDB_ADR_DEVCRC, {16'h0, host.crc16(w)}, 32'hFFFF);
      end
      cmd(`UDB_CMD_DONE);
      rd(`UDB_ADR_RXDATA, 32'h0, 32'h10000);
      wr(`UDB_ADR_CTRL, 32'h4A);
      cmd(`UDB_CMD_WRITE);
      w = 16'($urandom());
      host.tx_word(w, 1'b1);
      @(posedge ref_clk);
      rd(`UDB_ADR_ERROR, 32'h84, 32'h84);
      rd(`UDB_ADR_CMD, 32'h3, 32'h3);
      rd(`UDB_ADR_STATUS, 32'h81, 32'h89);
      rd(`UDB_ADR_RXDATA, {15'h0, 1'b1, w}, 32'h1FFFF);
      cmd(`UDB_CMD_DONE);
      wr(`UDB_ADR_CTRL, 32'h1B);
      wr(`UDB_ADR_RESET, {30'h0, `UDB_RST_SOFT});
      rd(`UDB_ADR_CTRL, 32'h1B, 32'h1F);
      wr(`UDB_ADR_CTRL, 32'hB);
      wr(`UDB_ADR_RESET, {30'h0, `UDB_RST_SOFT});
      rd(`UDB_ADR_CTRL, 32'h0, 32'h8);
      wr(`UDB_ADR_CTRL, 32'h1B);
      wr(`UDB_ADR_RESET, {30'h0, `UDB_RST_HARD});
      rd(`UDB_ADR_CTRL, 32'h0, 32'h7F);
      wr(`UDB_ADR_CTRL, 32'h1B);
      reset_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rd(`UDB_ADR_CTRL, 32'h0, 32'h7F);
      `UDB_CHK(exp_q.size(), 0, "reads left unanswered")
      test_done();
   end
endmodule // testbench

// File: udb_crc16.v
// CRC-16 update for one 16-bit burst word.
// Assumes the caller holds the running value in its own register.
`timescale 1ns/1ps
`include "udb_defines.vh"
module udb_crc16 (
   crc_in,
   data_in,
   crc_out
);
   input  wire [15:0] crc_in;
   input  wire [15:0] data_in;
   output reg  [15:0] crc_out;

   integer i;
   reg     fb;

   // ============================================================
   // Bit-serial CRC, most significant data bit first.
   always @* begin
      crc_out = crc_in;
      fb      = 1'b0;
      for (i = 15; i >= 0; i = i - 1) begin
         fb      = crc_out[15] ^ data_in[i];
         crc_out = {crc_out[14:0], 1'b0};
         if (fb) begin
            crc_out = crc_out ^ `UDB_CRC_POLY;
         end
      end
   end
endmodule // udb_crc16

// File: udb_defines.vh
// Constants for the device-side Ultra DMA burst port.
// Assumes inclusion by the burst port modules, the host model and the testbench.
`ifndef UDB_DEFINES_VH
`define UDB_DEFINES_VH
// ============================================================
// Register offsets (byte addresses, one 32-bit word each)
`define UDB_ADR_CTRL      8'h00
`define UDB_ADR_CMD       8'h04
`define UDB_ADR_STATUS    8'h08
`define UDB_ADR_ERROR     8'h0C
`define UDB_ADR_TXDATA    8'h10
`define UDB_ADR_RXDATA    8'h14
`define UDB_ADR_HOSTCRC   8'h18
`define UDB_ADR_DEVCRC    8'h1C
`define UDB_ADR_RESET     8'h20
// ============================================================
// Control register fields
`define UDB_CTRL_MODE_LSB 0
`define UDB_CTRL_MODE_MSB 2
`define UDB_CTRL_UDMA_EN  3
`define UDB_CTRL_NOREVERT 4
`define UDB_CTRL_MEMMODE  5
`define UDB_CTRL_ABORT    6
`define UDB_CTRL_RST      8'h00
`define UDB_MAX_MODE      3'h4
// ============================================================
// Command register codes
`define UDB_CMD_NONE      2'h0
`define UDB_CMD_READ      2'h1
`define UDB_CMD_WRITE     2'h2
`define UDB_CMD_DONE      2'h3
// ============================================================
// Status and error register bits
`define UDB_ST_BSY        7
`define UDB_ST_DRQ        3
`define UDB_ST_ERR        0
`define UDB_ER_ICRC       7
`define UDB_ER_ABRT       2
// ============================================================
// Reset register codes
`define UDB_RST_SOFT      2'h1
`define UDB_RST_HARD      2'h2
// ============================================================
// CRC definition
`define UDB_CRC_SEED      16'h4ABA
`define UDB_CRC_POLY      16'h1021
// ============================================================
// Timing: data settle before strobe edge
`define UDB_DVS_NS        70
`define UDB_CLK_NS        8
`define UDB_DVS_CYC       ((`UDB_DVS_NS + `UDB_CLK_NS - 1) / `UDB_CLK_NS)
`endif

// File: udb_host_model.sv
// Host partner for the burst port: one-word data-in and data-out bursts.
// Assumes a free-running link clock unrelated in phase to the device clock.
`timescale 1ns/1ps
`include "udb_defines.vh"
module udb_host_model (
   input  wire        hclk,
   input  wire        dmarq_o,
   input  wire        drdy_strobe_o,
   input  wire [15:0] data_o,
   input  wire        data_oe,
   output logic       dmack_i,
   output logic       stop_i,
   output logic       hrdy_strobe_i,
   output wire [15:0] data_i
);
   logic        hoe_r = 1'b0;
   logic [15:0] hd_r = 16'h0;
   logic [15:0] last_r = 16'h0;
   integer      n;
   // ====================
   // Bus and bursts
   // Termination is left to the device, so stop is never raised.
   // The model has no card enable or address lines, so none of them moves in a burst.
   initial begin
      dmack_i = 1'b0;
      stop_i = 1'b0;
      hrdy_strobe_i = 1'b0;
   end
   // A released bus toggles so that a stale word never reads as fresh.
   assign data_i = hoe_r ? hd_r : (data_oe ? data_o : ~last_r);
   always @(posedge hclk) last_r <= data_i;
   function automatic logic [15:0] crc16(input logic [15:0] d);
      logic [15:0] c;
      c = `UDB_CRC_SEED;
      for (int i = 15; i >= 0; i--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `UDB_CRC_POLY : 16'h0);
      crc16 = c;
   endfunction
   task automatic rx_word(output logic [15:0] w, input logic bad);
      logic s;
      @(posedge hclk);
      for (n = 0; n < 60 && !dmarq_o; n++) @(posedge hclk);
      hrdy_strobe_i <= 1'b1;
      dmack_i <= 1'b1;
      s = drdy_strobe_o;
      for (n = 0; n < 60 && drdy_strobe_o === s; n++) @(posedge hclk);
      w = data_i;
      for (n = 0; n < 60 && dmarq_o; n++) @(posedge hclk);
      hd_r <= crc16(w) ^ {15'h0, bad};
      hoe_r <= 1'b1;
      @(posedge hclk);
      dmack_i <= 1'b0;
      hrdy_strobe_i <= 1'b0;
      @(posedge hclk);
      hoe_r <= 1'b0;
   endtask
   task automatic tx_word(input logic [15:0] w, input logic bad);
      @(posedge hclk);
      for (n = 0; n < 60 && !dmarq_o; n++) @(posedge hclk);
      dmack_i <= 1'b1;
      for (n = 0; n < 60 && !drdy_strobe_o; n++) @(posedge hclk);
      hd_r <= w;
      hoe_r <= 1'b1;
      @(posedge hclk);
      hrdy_strobe_i <= ~hrdy_strobe_i;
      for (n = 0; n < 60 && dmarq_o; n++) @(posedge hclk);
      hd_r <= crc16(w) ^ {15'h0, bad};
      @(posedge hclk);
      dmack_i <= 1'b0;
      @(posedge hclk);
      hoe_r <= 1'b0;
   endtask
endmodule // udb_host_model

// File: udb_monitor.sv
// Checker for the burst port: register handshake and burst pin relations.
// Assumes it is bound to udb_port and sees only that module's ports.
`timescale 1ns/1ps
module udb_monitor (
   input wire        ref_clk,
   input wire        reset_n,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire        wb_ack_o,
   input wire        dmack_i,
   input wire        dmarq_o,
   input wire        drdy_strobe_o,
   input wire [15:0] data_o,
   input wire        data_oe
);
   // ====================
   // Properties
   default clocking mon_cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   chk_ack_delay:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   chk_ack_pulse:
      assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_ack_cause:
      assert property (wb_ack_o |-> wb_cyc_i && $past(wb_stb_i))
      else $error("ack without request");
   chk_oe_cause:
      assert property ($rose(data_oe) |-> dmarq_o && $past(dmack_i, 2))
      else $error("bus driven without request and acknowledge");
   chk_oe_release:
      assert property (!dmack_i [*6] |-> !data_oe)
      else $error("bus still driven after acknowledge fell");
   chk_data_settle:
      assert property (data_oe && $changed(drdy_strobe_o) |->
         $past(data_oe, 8) && $past(data_o, 8) == data_o)
      else $error("strobe edge before data settled");
   chk_strobe_once:
      assert property (data_oe && $changed(drdy_strobe_o) |=> $stable(drdy_strobe_o) [*2])
      else $error("extra strobe edge for one word");
   chk_wrdy_cause:
      assert property ($rose(drdy_strobe_o) && !data_oe |-> dmarq_o && $past(dmack_i, 2))
      else $error("device ready outside a write burst");
   cov_read: cover property ($rose(data_oe));
   cov_write: cover property ($rose(drdy_strobe_o) && !data_oe);
   cov_wr_ack: cover property (wb_ack_o && wb_we_i);
endmodule // udb_monitor

bind udb_port udb_monitor u_mon (.ref_clk(ref_clk), .reset_n(reset_n),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
   .dmack_i(dmack_i), .dmarq_o(dmarq_o), .drdy_strobe_o(drdy_strobe_o),
   .data_o(data_o), .data_oe(data_oe));

// File: udb_port.v
// Device-side Ultra DMA burst port with a Wishbone register slave.
// Assumes host-side pins are asynchronous to ref_clk and active high here.
// What this block does
// - With UDMA enabled, DMA read and write use burst protocol.
// - Lines take burst meanings only with mode, command, request and acknowledge.
// - Lines revert to normal meaning once the host negates acknowledge.
// - In read bursts host input is ready, device output is strobe.
// - In write bursts host input is strobe, device output is ready.
// - Each strobe edge, rising or falling, moves one word.
// - The sender drives both the data bus and the strobe.
// - Data settles on the bus before the latching strobe edge.
// - Host picks one mode, not above the fastest supported.
// - Soft reset keeps mode when reverting is disabled, else falls back.
// - Power-on or hard reset clears the selected UDMA mode.
// - Device compares host CRC with its own and flags mismatch.
// - Across bursts of one command the first error is reported.
// - A CRC error mid-command may abort or finish, always reported.
// - Every burst word is 16 bits wide.
// - In memory mode READY stays busy for the whole DMA command.
// - While a command runs, BSY or DRQ stays set.
// - A burst spans acknowledge assertion to acknowledge negation.
// - As recipient the device takes one word, then drops ready and ends the burst.
`timescale 1ns/1ps
`include "udb_defines.vh"
module udb_port (
   ref_clk,
   reset_n,
   wb_cyc_i,
   wb_stb_i,
   wb_we_i,
   wb_adr_i,
   wb_sel_i,
   wb_dat_i,
   wb_dat_o,
   wb_ack_o,
   dmack_i,
   stop_i,
   hrdy_strobe_i,
   dmarq_o,
   drdy_strobe_o,
   ready_o,
   data_i,
   data_o,
   data_oe
);
   input  wire        ref_clk;
   input  wire        reset_n;
   input  wire        wb_cyc_i;
   input  wire        wb_stb_i;
   input  wire        wb_we_i;
   input  wire [7:0]  wb_adr_i;
   input  wire [3:0]  wb_sel_i;
   input  wire [31:0] wb_dat_i;
   output reg  [31:0] wb_dat_o;
   output reg         wb_ack_o;
   input  wire        dmack_i;
   input  wire        stop_i;
   input  wire        hrdy_strobe_i;
   output reg         dmarq_o;
   output reg         drdy_strobe_o;
   output reg         ready_o;
   input  wire [15:0] data_i;
   output reg  [15:0] data_o;
   output reg         data_oe;

   localparam ST_IDLE = 3'h0;
   localparam ST_REQ  = 3'h1;
   localparam ST_XFER = 3'h2;
   localparam ST_CRC  = 3'h3;
   localparam ST_END  = 3'h4;
   localparam [31:0] DVS_CYC = `UDB_DVS_CYC;

   // ============================================================
   // Reset release and pin synchronisers.
   reg        rst_a_r;
   reg        rst_b_r;
   reg [1:0]  ack_s_r;
   reg [1:0]  stp_s_r;
   reg [1:0]  stb_s_r;
   reg        stb_d_r;
   reg [15:0] dat_a_r;
   reg [15:0] dat_b_r;
   wire       rst_n = rst_b_r;

   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_a_r <= 1'b0;
         rst_b_r <= 1'b0;
      end else begin
         rst_a_r <= 1'b1;
         rst_b_r <= rst_a_r;
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_s_r <= 2'h0;
         stp_s_r <= 2'h0;
         stb_s_r <= 2'h0;
         stb_d_r <= 1'b0;
         dat_a_r <= 16'h0000;
         dat_b_r <= 16'h0000;
      end else begin
         ack_s_r <= {ack_s_r[0], dmack_i};
         stp_s_r <= {stp_s_r[0], stop_i};
         stb_s_r <= {stb_s_r[0], hrdy_strobe_i};
         stb_d_r <= stb_s_r[1];
         dat_a_r <= data_i;
         dat_b_r <= dat_a_r;
      end
   end

   wire dmack   = ack_s_r[1];
   wire stop    = stp_s_r[1];
   wire hline   = stb_s_r[1];
   wire h_edge  = hline ^ stb_d_r;

   // ============================================================
   // Registers.
   reg [7:0]  ctrl_r;
   reg [2:0]  saved_mode_r;
   reg [1:0]  cmd_r;
   reg        busy_r;
   reg        drq_r;
   reg [7:0]  err_r;
   reg [15:0] tx_r;
   reg        tx_full_r;
   reg [15:0] rx_r;
   reg        rx_full_r;
   reg [15:0] hcrc_r;
   reg [15:0] crc_r;
   reg [2:0]  st_r;
   reg [3:0]  dly_r;
   wire [15:0] crc_nxt;

   wire udma_on = ctrl_r[`UDB_CTRL_UDMA_EN];
   wire memmode = ctrl_r[`UDB_CTRL_MEMMODE];
   wire is_read = (cmd_r == `UDB_CMD_READ);
   wire is_wr   = (cmd_r == `UDB_CMD_WRITE);
   wire in_cmd  = is_read | is_wr;
   wire wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wb_wr   = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

   function hit;
      input [7:0] a;
      input [7:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   function [2:0] clamp_mode;
      input [2:0] m;
      begin
         clamp_mode = (m > `UDB_MAX_MODE) ? `UDB_MAX_MODE : m;
      end
   endfunction

   wire rx_word = (st_r == ST_XFER) && is_wr && h_edge && !stop;
   wire tx_take = (st_r == ST_XFER) && is_read && tx_full_r && hline && !stop
                  && (dly_r == 4'h0);

   udb_crc16 u_crc (
      .crc_in  (crc_r),
      .data_in (is_read ? tx_r : dat_b_r),
      .crc_out (crc_nxt)
   );

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r       <= `UDB_CTRL_RST;
         saved_mode_r <= 3'h0;
         cmd_r        <= `UDB_CMD_NONE;
         busy_r       <= 1'b0;
         drq_r        <= 1'b0;
         err_r        <= 8'h00;
         tx_r         <= 16'h0000;
         tx_full_r    <= 1'b0;
         rx_r         <= 16'h0000;
         rx_full_r    <= 1'b0;
         hcrc_r       <= 16'h0000;
         crc_r        <= `UDB_CRC_SEED;
         st_r         <= ST_IDLE;
         dly_r        <= 4'h0;
         dmarq_o      <= 1'b0;
         drdy_strobe_o <= 1'b0;
         data_o       <= 16'h0000;
         data_oe      <= 1'b0;
         ready_o      <= 1'b1;
      end else begin
         // Software side.
         if (wb_wr && hit(wb_adr_i, `UDB_ADR_CTRL)) begin
            ctrl_r       <= {wb_dat_i[7:3], clamp_mode(wb_dat_i[2:0])};
            saved_mode_r <= clamp_mode(wb_dat_i[2:0]);
         end
         if (wb_wr && hit(wb_adr_i, `UDB_ADR_CMD) && udma_on) begin
            cmd_r  <= wb_dat_i[1:0];
            busy_r <= (wb_dat_i[1:0] != `UDB_CMD_NONE);
            err_r  <= 8'h00;
            crc_r  <= `UDB_CRC_SEED;
            if (wb_dat_i[1:0] != `UDB_CMD_NONE && memmode) begin
               ready_o <= 1'b0;
            end
         end
         if (wb_wr && hit(wb_adr_i, `UDB_ADR_RESET)) begin
            cmd_r   <= `UDB_CMD_NONE;
            busy_r  <= 1'b0;
            drq_r   <= 1'b0;
            ready_o <= 1'b1;
            if (wb_dat_i[1:0] == `UDB_RST_HARD) begin
               ctrl_r <= `UDB_CTRL_RST;
            end else if (wb_dat_i[1:0] == `UDB_RST_SOFT &&
                         !ctrl_r[`UDB_CTRL_NOREVERT]) begin
               ctrl_r[`UDB_CTRL_UDMA_EN] <= 1'b0;
            end else begin
               ctrl_r[2:0] <= saved_mode_r;
            end
         end
         if (wb_wr && hit(wb_adr_i, `UDB_ADR_TXDATA) && !tx_full_r) begin
            tx_r      <= wb_dat_i[15:0];
            tx_full_r <= 1'b1;
         end
         if (wb_cyc_i && wb_stb_i && wb_ack_o && !wb_we_i && hit(wb_adr_i, `UDB_ADR_RXDATA)) begin
            rx_full_r <= 1'b0;
         end
         // Link side state machine.
         case (st_r)
            ST_IDLE: begin
               data_oe       <= 1'b0;
               drdy_strobe_o <= 1'b0;
               if (in_cmd && udma_on && (is_wr ? !rx_full_r : tx_full_r)) begin
                  dmarq_o <= 1'b1;
                  st_r    <= ST_REQ;
               end
            end
            ST_REQ: begin
               if (!in_cmd) begin
                  dmarq_o <= 1'b0;
                  st_r    <= ST_IDLE;
               end else if (dmack) begin
                  st_r  <= ST_XFER;
                  dly_r <= DVS_CYC[3:0];
                  crc_r <= `UDB_CRC_SEED;
                  drq_r <= 1'b1;
                  busy_r <= 1'b0;
                  if (is_wr) begin
                     drdy_strobe_o <= 1'b1;
                  end
               end
            end
            ST_XFER: begin
               if (dly_r != 4'h0) dly_r <= dly_r - 4'h1;
               if (is_read && !stop) begin
                  data_oe <= 1'b1;
                  data_o  <= tx_r;
               end
               if (tx_take) begin
                  drdy_strobe_o <= ~drdy_strobe_o;
                  crc_r         <= crc_nxt;
                  tx_full_r     <= 1'b0;
                  dly_r         <= DVS_CYC[3:0];
               end
               if (rx_word) begin
                  rx_r      <= dat_b_r;
                  rx_full_r <= 1'b1;
                  crc_r     <= crc_nxt;
               end
               if (is_wr && rx_full_r) begin
                  drdy_strobe_o <= 1'b0;
               end
               if (stop || (is_read && !tx_full_r) || (is_wr && rx_full_r)) begin
                  dmarq_o <= 1'b0;
                  st_r    <= ST_CRC;
               end
            end
            ST_CRC: begin
               if (is_read) drdy_strobe_o <= 1'b1;
               if (!dmack) begin
                  data_oe <= 1'b0;
                  hcrc_r  <= dat_b_r;
                  st_r    <= ST_END;
               end
            end
            ST_END: begin
               busy_r <= 1'b1;
               drq_r  <= 1'b0;
               if (hcrc_r != crc_r && !err_r[`UDB_ER_ICRC]) begin
                  if (err_r == 8'h00) begin
                     err_r[`UDB_ER_ICRC] <= 1'b1;
                  end
                  if (ctrl_r[`UDB_CTRL_ABORT]) begin
                     err_r[`UDB_ER_ABRT] <= 1'b1;
                     cmd_r               <= `UDB_CMD_DONE;
                  end
               end
               st_r <= ST_IDLE;
            end
            default: st_r <= ST_IDLE;
         endcase
         if (wb_wr && hit(wb_adr_i, `UDB_ADR_CMD) && wb_dat_i[1:0] == `UDB_CMD_DONE
             && (st_r == ST_IDLE || st_r == ST_REQ)) begin
            cmd_r   <= `UDB_CMD_NONE;
            busy_r  <= 1'b0;
            ready_o <= 1'b1;
         end
      end
   end

   // ============================================================
   // Wishbone answer: ack one cycle after the request, dropped next cycle.
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req) begin
            case (wb_adr_i)
               `UDB_ADR_CTRL:    wb_dat_o <= {24'h000000, ctrl_r};
               `UDB_ADR_CMD:     wb_dat_o <= {30'h00000000, cmd_r};
               `UDB_ADR_STATUS:  wb_dat_o <= {24'h000000, busy_r, 3'h0, drq_r, 2'h0,
                                              (err_r != 8'h00)};
               `UDB_ADR_ERROR:   wb_dat_o <= {24'h000000, err_r};
               `UDB_ADR_TXDATA:  wb_dat_o <= {31'h00000000, tx_full_r};
               `UDB_ADR_RXDATA:  wb_dat_o <= {15'h0000, rx_full_r, rx_r};
               `UDB_ADR_HOSTCRC: wb_dat_o <= {16'h0000, hcrc_r};
               `UDB_ADR_DEVCRC:  wb_dat_o <= {16'h0000, crc_r};
               default:          wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule // udb_port
